/* tcr_defs.svh */
// Address map, bit positions, reset values and mode codes of the timer register block.
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH

// ----------------------------------------------------------------
// I/O address map
// ----------------------------------------------------------------
`define TCR_GRP_BIT    5
`define TCR_TSEL_BIT   4
`define TCR_PAIR_CNT   3'h0
`define TCR_PAIR_CMPA  3'h1
`define TCR_PAIR_CAP   3'h4
`define TCR_PAIR_FORCE 3'h5
`define TCR_ADDR_MASK  6'h20
`define TCR_ADDR_EMASK 6'h21
`define TCR_ADDR_FLAGS 6'h22
`define TCR_ADDR_EFLAG 6'h23

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define TCR_FOC_A      7
`define TCR_T1_CAP     5
`define TCR_T1_CMPA    4
`define TCR_T1_CMPB    3
`define TCR_T1_OVF     2
`define TCR_T3_CAP     5
`define TCR_T3_CMPA    4
`define TCR_T3_CMPB    3
`define TCR_T3_OVF     2
`define TCR_T3_CMPC    1
`define TCR_T1_CMPC    0
`define TCR_FLAG_IMPL  8'h3C
`define TCR_EFLAG_IMPL 8'h3F
`define TCR_EMASK_W    6

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define TCR_RST8       8'h00
`define TCR_RST16      16'h0000
`define TCR_MAX        16'hFFFF
`define TCR_ONE16      16'h0001

// ----------------------------------------------------------------
// Waveform modes and compare output actions
// ----------------------------------------------------------------
`define TCR_MODE_NORM  4'h0
`define TCR_MODE_CTCA  4'h4
`define TCR_MODE_PFCI  4'h8
`define TCR_MODE_PCI   4'hA
`define TCR_MODE_CTCI  4'hC
`define TCR_MODE_FSTI  4'hE
`define TCR_COM_OFF    2'h0
`define TCR_COM_TOG    2'h1
`define TCR_COM_CLR    2'h2
`define TCR_COM_SET    2'h3

`endif

/* tcr_pkg.sv */
// Types shared by the timer register block.
package tcr_pkg;

  typedef struct packed {
    logic [3:0]      waveformModeSel;
    logic [2:0][1:0] compareOutputAction;
    logic            captureEdgeRise;
    logic            captureFromComparator;
  } tcr_cfg_t;

  typedef struct packed {
    logic       capture;
    logic       overflow;
    logic [2:0] match;
  } tcr_evt_t;

endpackage

/* tcr_wave_chan.sv */
// One compare output channel: applies a match or a forced match to its pin.
`timescale 1ns/1ns
`include "tcr_defs.svh"

module tcr_wave_chan (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       match,
  input  wire logic       force_cmp,
  input  wire logic [1:0] compareOutputAction,
  output logic            compareOutputPin,
  output logic            compareOutputOe
);

  logic pin_r;
  logic pin_nxt;

  always_comb begin
    pin_nxt = pin_r;
    if (match | force_cmp) begin
      case (compareOutputAction)
        `TCR_COM_TOG: pin_nxt = ~pin_r;
        `TCR_COM_CLR: pin_nxt = 1'b0;
        `TCR_COM_SET: pin_nxt = 1'b1;
        default:      pin_nxt = pin_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign compareOutputPin = pin_r;
  // The pin is only claimed while an action is selected.
  assign compareOutputOe  = (compareOutputAction != `TCR_COM_OFF);

endmodule

/* tcr_timer_unit.sv */
// One 16-bit timer: counter, three compare values, capture value and event pulses.
`timescale 1ns/1ns
`include "tcr_defs.svh"

module tcr_timer_unit #(
  parameter bit HAS_COMPARATOR = 1'b1
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                timerTick,
  input  wire tcr_pkg::tcr_cfg_t   cfg,
  input  wire logic                capture_input_pin,
  input  wire logic                comparatorOut,
  input  wire logic                wrCounter,
  input  wire logic [2:0]          wrCompare,
  input  wire logic                wrCapture,
  input  wire logic [15:0]         wrData,
  output logic [15:0]              counter_value,
  output logic [2:0][15:0]         compare_value,
  output logic [15:0]              capture_value,
  output tcr_pkg::tcr_evt_t        evt
);

  logic [15:0]      cnt_r, cnt_nxt, cap_r, cap_nxt, top;
  logic [2:0][15:0] cmp_r, cmp_nxt;
  logic             blk_r, blk_nxt, src_r, src_nxt;
  logic             capTop, src, edgeSeen, atTop, wrapBlocked;

  // ----------------------------------------------------------------
  // Top selection and events
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg.waveformModeSel)
      `TCR_MODE_PFCI, `TCR_MODE_PCI,
      `TCR_MODE_CTCI, `TCR_MODE_FSTI: capTop = 1'b1;
      default:                        capTop = 1'b0;
    endcase
  end

  assign top = capTop ? cap_r :
               (cfg.waveformModeSel == `TCR_MODE_CTCA) ? cmp_r[0] : `TCR_MAX;
  assign atTop = (cnt_r == top);
  assign src = (HAS_COMPARATOR && cfg.captureFromComparator) ? comparatorOut :
               capture_input_pin;
  assign edgeSeen = cfg.captureEdgeRise ? (src & ~src_r) : (~src & src_r);
  // A write to the counter also cancels the compare-driven wrap in CLEAR_ON_COMPARE_MODE on channel A.
  assign wrapBlocked = blk_r & (cfg.waveformModeSel == `TCR_MODE_CTCA);

  generate
    for (genvar i = 0; i < 3; i++) begin : g_match
      assign evt.match[i] = timerTick & ~blk_r & (cnt_r == cmp_r[i]);
    end
  endgenerate

  assign evt.overflow = timerTick & (cnt_r == `TCR_MAX);
  // With the capture value as top, the pin is disconnected and top sets the flag.
  assign evt.capture  = capTop ? (timerTick & atTop) : edgeSeen;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    cmp_nxt = cmp_r;
    cap_nxt = cap_r;
    blk_nxt = blk_r;
    src_nxt = src;
    if (timerTick) begin
      blk_nxt = 1'b0;
      cnt_nxt = (atTop && !wrapBlocked) ? `TCR_RST16 : cnt_r + `TCR_ONE16;
    end
    if (edgeSeen && !capTop) begin
      cap_nxt = cnt_r;
    end
    if (wrCounter) begin
      cnt_nxt = wrData;
      blk_nxt = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (wrCompare[i]) begin
        cmp_nxt[i] = wrData;
      end
    end
    if (wrCapture) begin
      cap_nxt = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= `TCR_RST16;
      cmp_r <= {3{`TCR_RST16}};
      cap_r <= `TCR_RST16;
      blk_r <= 1'b0;
      src_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      cmp_r <= cmp_nxt;
      cap_r <= cap_nxt;
      blk_r <= blk_nxt;
      src_r <= src_nxt;
    end
  end

  assign counter_value = cnt_r;
  assign compare_value = cmp_r;
  assign capture_value = cap_r;

endmodule

/* tcr_timer16_regs.sv */
// Register block of the two 16-bit timers: byte access, shared high-byte latch, flags, masks.
`timescale 1ns/1ns
`include "tcr_defs.svh"

// Notes on behaviour
// - Force strobes ignored outside non-PWM modes
// - Force strobe applies channel output action now
// - Force strobe raises no flag, no clear
// - Force bits always read back zero
// - Force A, B, C at bits 7,6,5
// - Counter reachable as two bytes, shared latch
// - Counter write blocks next tick's compare match
// - Compare values compared with counter continuously
// - Compare writes commit both bytes together
// - Capture loads counter on pin event, or comparator event on timer 1 only
// - Capture value serves as top when selected
// - Capture reads take both bytes from one value
// - Request needs enable, global enable and flag
// - Timer 1 enables at mask bits 5..2
// - Extended mask: timer 3 bits 5..1, bit 0
// - Extended mask absent in legacy mode
// - Compare flag set after match, never forced
// - Flags clear on vector or written one
// - Non-PWM modes are 0, 4 and 12

module tcr_timer16_regs (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [5:0]              ioAddr,
  input  wire logic [7:0]              ioWrData,
  input  wire logic                    ioWe,
  input  wire logic                    ioRe,
  output logic [7:0]                   ioRdData,
  input  wire tcr_pkg::tcr_cfg_t [1:0] timerCfg,
  input  wire logic [1:0]              timerTick,
  input  wire logic [1:0]              capture_input_pin,
  input  wire logic                    comparatorOut,
  input  wire logic                    globalIrqEn,
  input  wire logic                    legacyMode,
  input  wire logic [7:0]              vectorAckFlags,
  input  wire logic [7:0]              vectorAckExtFlags,
  output logic [7:0]                   irqReqFlags,
  output logic [7:0]                   irqReqExtFlags,
  output logic [5:0]                   compare_output_pin,
  output logic [5:0]                   compareOutputOe
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Force strobes only act in the modes without PWM.
  function automatic logic nonPwm(input logic [3:0] mode);
    nonPwm = (mode == `TCR_MODE_NORM) || (mode == `TCR_MODE_CTCA) ||
             (mode == `TCR_MODE_CTCI);
  endfunction

  function automatic logic isWordPair(input logic [5:0] a);
    isWordPair = !a[`TCR_GRP_BIT] && (a[3:1] <= `TCR_PAIR_CAP);
  endfunction

  function automatic logic isForceReg(input logic [5:0] a);
    isForceReg = !a[`TCR_GRP_BIT] && (a[3:0] == {`TCR_PAIR_FORCE, 1'b0});
  endfunction

  function automatic logic [15:0] pickWord(
    input logic [2:0]       pair,
    input logic [15:0]      c,
    input logic [2:0][15:0] m,
    input logic [15:0]      cp
  );
    case (pair)
      `TCR_PAIR_CNT: pickWord = c;
      `TCR_PAIR_CAP: pickWord = cp;
      default:       pickWord = m[2'(pair - `TCR_PAIR_CMPA)];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]               temp_r, temp_nxt;
  logic [7:0]               rd_r, rd_nxt;
  logic [7:0]               mask_r, mask_nxt;
  logic [`TCR_EMASK_W-1:0]  emask_r, emask_nxt;
  logic [7:0]               flag_r, flag_nxt;
  logic [7:0]               eflag_r, eflag_nxt;

  logic [1:0][15:0]         cntV, capV;
  logic [1:0][2:0][15:0]    cmpV;
  tcr_pkg::tcr_evt_t [1:0]  evt;
  logic [1:0]               wrLow;
  logic [1:0][2:0]          forceV;
  logic [7:0]               flagSet, eflagSet, flagClr, eflagClr;
  logic [15:0]              wrWord;
  logic                     tsel;

  assign tsel   = ioAddr[`TCR_TSEL_BIT];
  assign wrWord = {temp_r, ioWrData};

  // ----------------------------------------------------------------
  // Timers and their compare channels
  // ----------------------------------------------------------------
  generate
    for (genvar t = 0; t < 2; t++) begin : g_timer
      logic [2:0] wrCmp;

      assign wrLow[t] = ioWe && isWordPair(ioAddr) && (tsel == t) && !ioAddr[0];

      for (genvar i = 0; i < 3; i++) begin : g_chan
        assign wrCmp[i] = wrLow[t] && (ioAddr[3:1] == 3'(`TCR_PAIR_CMPA + i));
        // Strobes reach the output only, never the flags or the counter.
        assign forceV[t][i] = ioWe && isForceReg(ioAddr) && (tsel == t) &&
                              nonPwm(timerCfg[t].waveformModeSel) &&
                              ioWrData[`TCR_FOC_A - i];

        tcr_wave_chan u_chan (
          .clk                 (clk),
          .sys_rst             (sys_rst),
          .match               (evt[t].match[i]),
          .force_cmp           (forceV[t][i]),
          .compareOutputAction (timerCfg[t].compareOutputAction[i]),
          .compareOutputPin    (compare_output_pin[t*3+i]),
          .compareOutputOe     (compareOutputOe[t*3+i])
        );
      end

      tcr_timer_unit #(
        .HAS_COMPARATOR (t == 0)
      ) u_timer (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .timerTick         (timerTick[t]),
        .cfg               (timerCfg[t]),
        .capture_input_pin (capture_input_pin[t]),
        .comparatorOut     (comparatorOut),
        .wrCounter         (wrLow[t] && (ioAddr[3:1] == `TCR_PAIR_CNT)),
        .wrCompare         (wrCmp),
        .wrCapture         (wrLow[t] && (ioAddr[3:1] == `TCR_PAIR_CAP)),
        .wrData            (wrWord),
        .counter_value     (cntV[t]),
        .compare_value     (cmpV[t]),
        .capture_value     (capV[t]),
        .evt               (evt[t])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flag sources
  // ----------------------------------------------------------------
  // Matches are sampled on the tick, so a flag shows in the cycle after the match.
  always_comb begin
    flagSet                  = `TCR_RST8;
    flagSet[`TCR_T1_CAP]     = evt[0].capture;
    flagSet[`TCR_T1_CMPA]    = evt[0].match[0];
    flagSet[`TCR_T1_CMPB]    = evt[0].match[1];
    flagSet[`TCR_T1_OVF]     = evt[0].overflow;
    eflagSet                 = `TCR_RST8;
    eflagSet[`TCR_T3_CAP]    = evt[1].capture;
    eflagSet[`TCR_T3_CMPA]   = evt[1].match[0];
    eflagSet[`TCR_T3_CMPB]   = evt[1].match[1];
    eflagSet[`TCR_T3_OVF]    = evt[1].overflow;
    eflagSet[`TCR_T3_CMPC]   = evt[1].match[2];
    eflagSet[`TCR_T1_CMPC]   = evt[0].match[2];
  end

  assign flagClr  = vectorAckFlags |
                    ((ioWe && ioAddr == `TCR_ADDR_FLAGS) ? ioWrData : `TCR_RST8);
  assign eflagClr = vectorAckExtFlags |
                    ((ioWe && ioAddr == `TCR_ADDR_EFLAG) ? ioWrData : `TCR_RST8);

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] w;
    w         = pickWord(ioAddr[3:1], cntV[tsel], cmpV[tsel], capV[tsel]);
    temp_nxt  = temp_r;
    rd_nxt    = rd_r;
    mask_nxt  = mask_r;
    emask_nxt = emask_r;
    // A new event wins over a clear landing in the same cycle.
    flag_nxt  = ((flag_r & ~flagClr) | flagSet) & `TCR_FLAG_IMPL;
    eflag_nxt = ((eflag_r & ~eflagClr) | eflagSet) & `TCR_EFLAG_IMPL;

    if (ioRe) begin
      rd_nxt = `TCR_RST8;
      if (isWordPair(ioAddr)) begin
        if (!ioAddr[0]) begin
          rd_nxt   = w[7:0];
          temp_nxt = w[15:8];
        end else begin
          rd_nxt = temp_r;
        end
      end else begin
        case (ioAddr)
          `TCR_ADDR_MASK:  rd_nxt = mask_r;
          `TCR_ADDR_EMASK: rd_nxt = legacyMode ? `TCR_RST8 : {2'b00, emask_r};
          `TCR_ADDR_FLAGS: rd_nxt = flag_r;
          `TCR_ADDR_EFLAG: rd_nxt = eflag_r;
          default:         rd_nxt = `TCR_RST8;
        endcase
      end
    end

    if (ioWe) begin
      if (isWordPair(ioAddr) && ioAddr[0]) begin
        temp_nxt = ioWrData;
      end
      if (ioAddr == `TCR_ADDR_MASK) begin
        mask_nxt = ioWrData;
      end
      if (ioAddr == `TCR_ADDR_EMASK && !legacyMode) begin
        emask_nxt = ioWrData[`TCR_EMASK_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      temp_r  <= `TCR_RST8;
      rd_r    <= `TCR_RST8;
      mask_r  <= `TCR_RST8;
      emask_r <= '0;
      flag_r  <= `TCR_RST8;
      eflag_r <= `TCR_RST8;
    end else begin
      temp_r  <= temp_nxt;
      rd_r    <= rd_nxt;
      mask_r  <= mask_nxt;
      emask_r <= emask_nxt;
      flag_r  <= flag_nxt;
      eflag_r <= eflag_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  // Bits of the shared mask that belong to the 8-bit timers are stored but gate nothing here.
  assign irqReqFlags    = flag_r & mask_r & {8{globalIrqEn}} & `TCR_FLAG_IMPL;
  assign irqReqExtFlags = eflag_r & {2'b00, emask_r} &
                          {8{globalIrqEn && !legacyMode}};
  assign ioRdData       = rd_r;

endmodule

/* tcr_regs_props.sv */
// Port-level assertions of the timer register block.
`timescale 1ns/1ns
module tcr_regs_props (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic [5:0]              ioAddr,
  input wire logic [7:0]              ioWrData,
  input wire logic                    ioWe,
  input wire logic                    ioRe,
  input wire logic [7:0]              ioRdData,
  input wire tcr_pkg::tcr_cfg_t [1:0] timerCfg,
  input wire logic [1:0]              timerTick,
  input wire logic                    globalIrqEn,
  input wire logic                    legacyMode,
  input wire logic [7:0]              vectorAckFlags,
  input wire logic [7:0]              irqReqFlags,
  input wire logic [7:0]              irqReqExtFlags,
  input wire logic [5:0]              compare_output_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // Forced compare on timer 1, requests, flags and read data
  // ------------------------------------------------
  // A tick in the same cycle may move the pin by a real match, so it is left out.
  sequence s_force_pwm;
    ioWe && ioAddr == 6'h0A && !timerTick[0]
      && !(timerCfg[0].waveformModeSel inside {4'h0, 4'h4, 4'hC});
  endsequence
  sequence s_force_set_a;
    ioWe && ioAddr == 6'h0A && ioWrData[7] && !timerTick[0]
      && timerCfg[0].waveformModeSel == 4'h0 && timerCfg[0].compareOutputAction[0] == 2'h3;
  endsequence
  AST_FORCE_PWM: assert property (s_force_pwm |=> $stable(compare_output_pin[2:0]))
    else $error("force acted in a PWM mode");
  AST_FORCE_SET: assert property (s_force_set_a |=> compare_output_pin[0])
    else $error("force did not set pin A");
  AST_FORCE_RD: assert property (ioRe && ioAddr[4:0] == 5'h0A
    |=> ioRdData == 8'h00) else $error("force bits read nonzero");
  AST_IRQ_GLOBAL: assert property (irqReqFlags != 8'h00 |-> globalIrqEn)
    else $error("request without global enable");
  AST_MASK_BITS: assert property ((irqReqFlags & 8'hC3) == 8'h00)
    else $error("request on an unowned mask bit");
  AST_EXT_REQ: assert property (legacyMode || irqReqExtFlags[7:6] != 2'b00
    |-> irqReqExtFlags == 8'h00) else $error("extended request not allowed");
  AST_EMASK_RD: assert property (ioRe && ioAddr == 6'h21
    |=> ioRdData[7:6] == 2'b00 && (!$past(legacyMode) || ioRdData == 8'h00))
    else $error("extended mask read wrong");
  AST_ACK_CLR: assert property (vectorAckFlags[4] && !timerTick[0] |=> !irqReqFlags[4])
    else $error("vector did not clear flag");
  AST_NO_FORCE_FLAG: assert property ($rose(irqReqFlags[4]) && $stable(globalIrqEn)
    && !$past(ioWe) |-> $past(timerTick[0])) else $error("flag rose without a tick");
  AST_RD_HOLD: assert property (!ioRe |=> $stable(ioRdData))
    else $error("read data changed without a read");
endmodule

/* tcr_cpu_model.sv */
// CPU-side partner: byte register cycles and vector acknowledges.
`timescale 1ns/1ns
module tcr_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] ioRdData,
  output logic [5:0]      ioAddr,
  output logic [7:0]      ioWrData,
  output logic            ioWe,
  output logic            ioRe,
  output logic [7:0]      vectorAckFlags,
  output logic [7:0]      vectorAckExtFlags
);
  initial begin
    ioAddr = 6'h3F;
    ioWrData = 8'h00;
    ioWe = 1'b0;
    ioRe = 1'b0;
    vectorAckFlags = 8'h00;
    vectorAckExtFlags = 8'h00;
  end
  // Reserved bits of the force and extended mask registers go out as zero; idle lines show the inverse so stale data never passes.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a[3:0] == 4'hA && !a[5]) v = d & 8'hE0;
    if (a == 6'h21) v = d & 8'h3F;
    @(posedge clk);
    ioWe <= 1'b1;
    ioAddr <= a;
    ioWrData <= v;
    @(posedge clk);
    ioWe <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge clk);
    ioRe <= 1'b1;
    ioAddr <= a;
    @(posedge clk);
    ioRe <= 1'b0;
    ioAddr <= ~a;
    #1 q = ioRdData;
  endtask
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr(a | 6'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask
  task automatic rd16(input logic [5:0] a, output logic [15:0] q);
    rd(a, q[7:0]);
    rd(a | 6'h01, q[15:8]);
  endtask
  task automatic ack(input logic [7:0] f, input logic [7:0] e);
    @(posedge clk);
    vectorAckFlags <= f;
    vectorAckExtFlags <= e;
    @(posedge clk);
    vectorAckFlags <= 8'h00;
    vectorAckExtFlags <= 8'h00;
  endtask
endmodule

/* tcr_timer16_regs_test.sv */
// Self-checking bench of the timer register block.
`timescale 1ns/1ns
module tcr_timer16_regs_test;
  logic                    clk;
  logic                    sys_rst;
  logic [5:0]              ioAddr;
  logic [7:0]              ioWrData;
  logic                    ioWe;
  logic                    ioRe;
  logic [7:0]              ioRdData;
  tcr_pkg::tcr_cfg_t [1:0] timerCfg;
  logic [1:0]              timerTick;
  logic [1:0]              capPin;
  logic                    comparatorOut;
  logic                    globalIrqEn;
  logic                    legacyMode;
  logic [7:0]              ackF;
  logic [7:0]              ackE;
  logic [7:0]              irqF;
  logic [7:0]              irqE;
  logic [5:0]              pinOut;
  logic [5:0]              pinOe;
  logic [31:0]             seed;
  logic [5:0]              expPin;
  int                      mdl [int];
  int                      err_count;
  int                      tests_run;

  tcr_timer16_regs DUT (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWe(ioWe), .ioRe(ioRe), .ioRdData(ioRdData), .timerCfg(timerCfg), .timerTick(timerTick),
    .capture_input_pin(capPin), .comparatorOut(comparatorOut), .globalIrqEn(globalIrqEn),
    .legacyMode(legacyMode), .vectorAckFlags(ackF), .vectorAckExtFlags(ackE),
    .irqReqFlags(irqF), .irqReqExtFlags(irqE), .compare_output_pin(pinOut),
    .compareOutputOe(pinOe));
  tcr_cpu_model cpu (.clk(clk), .ioRdData(ioRdData), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioWe(ioWe), .ioRe(ioRe), .vectorAckFlags(ackF), .vectorAckExtFlags(ackE));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic c8(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic w16(input logic [5:0] a, input logic [15:0] v);
    cpu.wr16(a, v);
    mdl[a] = v;
  endtask
  task automatic c16(input logic [5:0] a);
    logic [15:0] q;
    cpu.rd16(a, q);
    chk(q, mdl[a][15:0]);
  endtask
  task automatic tick();
    @(posedge clk);
    timerTick[0] <= 1'b1;
    @(posedge clk);
    timerTick[0] <= 1'b0;
    mdl[0] = mdl[0] + 1;
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    timerCfg = '0;
    timerTick = 2'b00;
    capPin = 2'b00;
    comparatorOut = 1'b0;
    globalIrqEn = 1'b0;
    legacyMode = 1'b0;
    err_count = 0;
    tests_run = 0;
    seed = 32'h0000_b880;
    expPin = 6'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 64; a++) c8(6'(a), 8'h00);
    // Counters stay stopped while written, so every value reads back as written.
    for (int ph = 0; ph < 2; ph++) begin
      for (int r = 0; r < 10; r++) begin
        seed = xs(seed);
        if (ph == 0) w16(6'((r / 5) * 16 + (r % 5) * 2), seed[15:0]);
        else c16(6'((r / 5) * 16 + (r % 5) * 2));
      end
    end
    cpu.wr(6'h13, 8'hAB);
    cpu.wr(6'h04, 8'hCD);
    mdl[4] = 16'hABCD;
    c16(6'h04);
    c16(6'h12);
    @(posedge clk);
    timerCfg[0].compareOutputAction <= {2'h2, 2'h1, 2'h3};
    cpu.wr(6'h0A, 8'hE0);
    @(negedge clk);
    expPin = 6'h03;
    chk({10'h000, pinOut}, {10'h000, expPin});
    chk({10'h000, pinOe}, 16'h0007);
    c8(6'h0A, 8'h00);
    c8(6'h22, 8'h00);
    c8(6'h23, 8'h00);
    @(posedge clk);
    timerCfg[0].compareOutputAction <= 6'h15;
    for (int m = 0; m < 16; m++) begin
      @(posedge clk);
      timerCfg[0].waveformModeSel <= 4'(m);
      cpu.wr(6'h0A, 8'hE0);
      if (m inside {0, 4, 12}) expPin[2:0] = ~expPin[2:0];
      @(negedge clk);
      chk({10'h000, pinOut}, {10'h000, expPin});
    end
    c16(6'h00);
    @(posedge clk);
    timerCfg[0].waveformModeSel <= 4'h0;
    w16(6'h02, 16'h0005);
    w16(6'h00, 16'h0005);
    tick();
    c8(6'h22, 8'h00);
    w16(6'h00, 16'h0004);
    tick();
    tick();
    c8(6'h22, 8'h10);
    c16(6'h00);
    cpu.wr(6'h20, 8'h10);
    @(negedge clk);
    chk({8'h00, irqF}, 16'h0000);
    @(posedge clk);
    globalIrqEn <= 1'b1;
    @(negedge clk);
    chk({8'h00, irqF}, 16'h0010);
    cpu.wr(6'h22, 8'h10);
    c8(6'h22, 8'h00);
    w16(6'h00, 16'h0004);
    tick();
    tick();
    cpu.ack(8'h10, 8'h00);
    c8(6'h22, 8'h00);
    @(posedge clk);
    timerCfg[0].captureEdgeRise <= 1'b1;
    w16(6'h00, 16'h1234);
    @(posedge clk);
    capPin[0] <= 1'b1;
    repeat (2) @(posedge clk);
    mdl[8] = 16'h1234;
    c16(6'h08);
    c8(6'h22, 8'h20);
    @(posedge clk);
    timerCfg[0].waveformModeSel <= 4'hC;
    w16(6'h08, 16'h0003);
    w16(6'h00, 16'h0002);
    tick();
    tick();
    mdl[0] = 0;
    c16(6'h00);
    @(posedge clk);
    legacyMode <= 1'b1;
    cpu.wr(6'h21, 8'hFF);
    c8(6'h21, 8'h00);
    @(posedge clk);
    legacyMode <= 1'b0;
    cpu.wr(6'h21, 8'hFF);
    c8(6'h21, 8'h3F);
    @(posedge clk);
    timerCfg[0].waveformModeSel <= 4'h0;
    w16(6'h06, 16'h0007);
    w16(6'h00, 16'h0006);
    tick();
    tick();
    @(negedge clk);
    chk({8'h00, irqE}, 16'h0001);
    @(posedge clk);
    legacyMode <= 1'b1;
    @(negedge clk);
    chk({8'h00, irqE}, 16'h0000);
    tally_and_finish();
  end
endmodule

bind tcr_timer16_regs tcr_regs_props chk (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr),
  .ioWrData(ioWrData), .ioWe(ioWe), .ioRe(ioRe), .ioRdData(ioRdData), .timerCfg(timerCfg),
  .timerTick(timerTick), .globalIrqEn(globalIrqEn), .legacyMode(legacyMode),
  .vectorAckFlags(vectorAckFlags), .irqReqFlags(irqReqFlags), .irqReqExtFlags(irqReqExtFlags),
  .compare_output_pin(compare_output_pin));
